// ---- qpcs_consts.svh ----
// Offsets, field positions, codes and timing for the optical port register bank
`ifndef QPCS_CONSTS_SVH
`define QPCS_CONSTS_SVH

// Indirect 8-bit space
`define QPCS_OFF_MODCFG   24'h00_00a0
`define QPCS_OFF_PORTEN   24'h00_00a1
`define QPCS_OFF_PSTAT    24'h00_00a2
`define QPCS_OFF_MODST2   24'h00_00a3
`define QPCS_OFF_PINFO    24'h00_00a7
// Memory window, 32-bit
`define QPCS_OFF_SYNC     24'h84_0010
`define QPCS_OFF_FRMCNT   24'h84_0014
`define QPCS_OFF_LOCK     24'h84_0060
`define QPCS_OFF_RCADDR   24'h84_0064
`define QPCS_OFF_RCWDATA  24'h84_0068
`define QPCS_OFF_RCRDATA  24'h84_006c
`define QPCS_OFF_FREQEN   24'h84_0074
`define QPCS_OFF_FREQRX   24'h84_0078
`define QPCS_OFF_FREQTX   24'h84_007c
`define QPCS_OFF_PMODE    24'h84_0080
`define QPCS_OFF_PLOW     24'h84_0084
`define QPCS_OFF_PHIGH    24'h84_0088

// Module configuration byte
`define QPCS_CFG_INT      6
`define QPCS_CFG_PRES     5
`define QPCS_CFG_LOWPWR   2
`define QPCS_CFG_XCVREN   1
// Port status byte
`define QPCS_PST_RCFG     6
`define QPCS_PST_TXPLL    4
`define QPCS_PST_LOCKDAT  3
`define QPCS_PST_LOCKREF  2
`define QPCS_PST_RXRDY    1
`define QPCS_PST_TXRDY    0
// Port information
`define QPCS_PORT_TYPE    4'h1
`define QPCS_PORT_NUM     4'h4
// Sync trigger control
`define QPCS_SYNC_TXARM   15
`define QPCS_SYNC_THR     13:12
`define QPCS_SYNC_TXSRC   9:8
`define QPCS_SYNC_RXARM   7
`define QPCS_SYNC_NOWAIT  2
`define QPCS_SYNC_RXSRC   1:0
`define QPCS_SRC_EXT      2'h0
`define QPCS_SRC_INT      2'h1
`define QPCS_THR_NONE     2'h0
`define QPCS_THR_HALF     2'h1
`define QPCS_THR_3Q       2'h2
`define QPCS_THR_FULL     2'h3
// Reconfiguration address and control
`define QPCS_RC_ALLRST    18
`define QPCS_RC_BUSY      17
`define QPCS_RC_XRST      16
`define QPCS_RC_ADDR      15:0
// Pattern test group layout, one byte per lane and direction
`define QPCS_PT_GEN       0
`define QPCS_PT_CHK       1
`define QPCS_PT_SYNC      4
`define QPCS_PT_LERR      5
`define QPCS_PT_RERR      6
// Frequency gate timing
`define QPCS_FREQ_GATE_US 1000
`define QPCS_CLK_MHZ      40

`endif

// ---- qpcs_pkg.sv ----
// State types of the optical port register bank
package qpcs_pkg;

	typedef struct packed {
		logic        mod_lowpwr;
		logic        xcvr_en;
		logic [2:0]  port_en;
		logic        tx_arm;
		logic [1:0]  fifo_thr;
		logic [1:0]  tx_src;
		logic        rx_arm;
		logic        rx_nowait;
		logic [1:0]  rx_src;
		logic        tx_trigd;
		logic        rx_trigd;
		logic        tx_run;
		logic        rx_accept;
		logic        rcfg_all_rst;
		logic        xcvr_rst;
		logic [15:0] rcfg_addr;
		logic [31:0] rcfg_wdata;
		logic        freq_en;
		logic [7:0]  prbs_mode;
		logic [7:0]  prbs_gen;
		logic [7:0]  prbs_chk;
		logic [31:0] rdata;
		logic        rvalid;
	} qpcs_state_t;

	typedef struct packed {
		logic [15:0] gate;
		logic [23:0] acc;
		logic [23:0] value;
	} qpcs_fc_state_t;

endpackage : qpcs_pkg

// ---- qpcs_freq_counter.sv ----
// Gated tick counter giving one frequency reading per gate window
`timescale 1ns/1ps
`include "qpcs_consts.svh"

module qpcs_freq_counter #(
	parameter int GATE_CYCLES = `QPCS_FREQ_GATE_US * `QPCS_CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        tick,
	output logic      [23:0] count
);

	qpcs_pkg::qpcs_fc_state_t s_ff;
	qpcs_pkg::qpcs_fc_state_t nxt_s;

	// Gate window counting, reading kept while disabled
	always_comb begin
		nxt_s = s_ff;
		if (!enable) begin
			nxt_s.gate = '0;
			nxt_s.acc  = '0;
		end else if (s_ff.gate == 16'(GATE_CYCLES - 1)) begin
			nxt_s.value = s_ff.acc + {23'h00_0000, tick};
			nxt_s.gate  = '0;
			nxt_s.acc   = '0;
		end else begin
			nxt_s.gate = s_ff.gate + 16'h0001;
			nxt_s.acc  = s_ff.acc + {23'h00_0000, tick};
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign count = s_ff.value;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_freq_idle_hold: assert property (!enable |=> $stable(s_ff.value) && s_ff.gate == 16'h0000)
		else $error("frequency reading changed while disabled");
	c_freq_gate_done: cover property (enable && s_ff.gate == 16'(GATE_CYCLES - 1));

endmodule : qpcs_freq_counter

// ---- qpcs_port_regs.sv ----
// Control and status register bank of the four-lane optical port
`timescale 1ns/1ps
`include "qpcs_consts.svh"

module qpcs_port_regs #(
	parameter int FREQ_GATE_CYCLES = `QPCS_FREQ_GATE_US * `QPCS_CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [23:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        mod_int,
	input  wire logic        mod_present,
	output logic             mod_lowpwr,
	output logic             xcvr_en,
	output logic             second_pll_en,
	output logic             first_pll_en,
	output logic             line_if_en,
	input  wire logic        rcfg_in_progress,
	input  wire logic        tx_pll_locked,
	input  wire logic        clkrec_lock_data,
	input  wire logic        clkrec_lock_ref,
	input  wire logic        rx_ready,
	input  wire logic        tx_ready,
	input  wire logic [3:0]  lane_lock_data,
	input  wire logic [3:0]  lane_lock_ref,
	input  wire logic        ext_trig,
	input  wire logic        int_trig,
	input  wire logic        fifo_half,
	input  wire logic        fifo_3q,
	input  wire logic        fifo_full,
	output logic             tx_run,
	output logic             rx_accept,
	input  wire logic        rcfg_busy,
	input  wire logic [31:0] rcfg_rdata,
	output logic             rcfg_all_rst,
	output logic             xcvr_rst,
	output logic      [15:0] rcfg_addr,
	output logic      [31:0] rcfg_wdata,
	input  wire logic        rx_freq_tick,
	input  wire logic        tx_freq_tick,
	output logic       [7:0] prbs_mode,
	output logic       [7:0] prbs_gen_en,
	output logic       [7:0] prbs_chk_en,
	input  wire logic  [7:0] prbs_sync,
	input  wire logic  [7:0] prbs_lerr,
	input  wire logic  [7:0] prbs_rerr
);

	qpcs_pkg::qpcs_state_t s_ff;
	qpcs_pkg::qpcs_state_t nxt_s;

	logic [23:0] rx_count;
	logic [23:0] tx_count;
	logic [63:0] prbs_img;
	logic  [7:0] lock_img;
	logic  [7:0] wr_gen;
	logic  [7:0] wr_chk;
	logic [31:0] rd_img;
	logic        tx_trig_hit;
	logic        rx_trig_hit;
	logic        thr_met;

	// Trigger source select: only codes 0 and 1 have a source
	function automatic logic trig_pick(input logic [1:0] src, input logic ext, input logic intl);
		logic hit;
		hit = 1'b0;
		case (src)
			`QPCS_SRC_EXT: hit = ext;
			`QPCS_SRC_INT: hit = intl;
			default:       hit = 1'b0;
		endcase
		return hit;
	endfunction : trig_pick

	// Frequency counters for both directions
	qpcs_freq_counter #(
		.GATE_CYCLES (FREQ_GATE_CYCLES)
	) u_rx_freq (
		.clk    (clk),
		.resetn (resetn),
		.enable (s_ff.freq_en),
		.tick   (rx_freq_tick),
		.count  (rx_count)
	);

	qpcs_freq_counter #(
		.GATE_CYCLES (FREQ_GATE_CYCLES)
	) u_tx_freq (
		.clk    (clk),
		.resetn (resetn),
		.enable (s_ff.freq_en),
		.tick   (tx_freq_tick),
		.count  (tx_count)
	);

	// Per lane and direction: pattern group image, write bits; per lane (first four groups only): lane lock pairs
	for (genvar g = 0; g < 8; g++) begin : g_group
		assign prbs_img[g*8 +: 8] = {1'b0, prbs_rerr[g], prbs_lerr[g], prbs_sync[g],
			2'b00, s_ff.prbs_chk[g], s_ff.prbs_gen[g]};
		assign wr_gen[g] = reg_wdata[(g % 4) * 8 + `QPCS_PT_GEN];
		assign wr_chk[g] = reg_wdata[(g % 4) * 8 + `QPCS_PT_CHK];
		if (g < 4) begin : g_lane
			assign lock_img[g*2 +: 2] = {lane_lock_data[g], lane_lock_ref[g]};
		end
	end

	// Read image of the addressed register, reserved bits zero
	always_comb begin
		rd_img = 32'h0000_0000;
		case (reg_addr)
			`QPCS_OFF_MODCFG: begin
				rd_img[`QPCS_CFG_INT]    = mod_int;
				rd_img[`QPCS_CFG_PRES]   = mod_present;
				rd_img[`QPCS_CFG_LOWPWR] = s_ff.mod_lowpwr;
				rd_img[`QPCS_CFG_XCVREN] = s_ff.xcvr_en;
			end
			`QPCS_OFF_PORTEN: rd_img[2:0] = s_ff.port_en;
			`QPCS_OFF_PSTAT: begin
				rd_img[`QPCS_PST_RCFG]    = rcfg_in_progress;
				rd_img[`QPCS_PST_TXPLL]   = tx_pll_locked;
				rd_img[`QPCS_PST_LOCKDAT] = clkrec_lock_data;
				rd_img[`QPCS_PST_LOCKREF] = clkrec_lock_ref;
				rd_img[`QPCS_PST_RXRDY]   = rx_ready;
				rd_img[`QPCS_PST_TXRDY]   = tx_ready;
			end
			`QPCS_OFF_PINFO: rd_img[7:0] = {`QPCS_PORT_TYPE, `QPCS_PORT_NUM};
			`QPCS_OFF_SYNC: begin
				rd_img[`QPCS_SYNC_TXARM]  = s_ff.tx_arm;
				rd_img[`QPCS_SYNC_THR]    = s_ff.fifo_thr;
				rd_img[`QPCS_SYNC_TXSRC]  = s_ff.tx_src;
				rd_img[`QPCS_SYNC_RXARM]  = s_ff.rx_arm;
				rd_img[`QPCS_SYNC_NOWAIT] = s_ff.rx_nowait;
				rd_img[`QPCS_SYNC_RXSRC]  = s_ff.rx_src;
			end
			`QPCS_OFF_LOCK: rd_img[7:0] = lock_img;
			`QPCS_OFF_RCADDR: begin
				rd_img[`QPCS_RC_ALLRST] = s_ff.rcfg_all_rst;
				rd_img[`QPCS_RC_BUSY]   = rcfg_busy;
				rd_img[`QPCS_RC_XRST]   = s_ff.xcvr_rst;
				rd_img[`QPCS_RC_ADDR]   = s_ff.rcfg_addr;
			end
			`QPCS_OFF_RCWDATA: rd_img = s_ff.rcfg_wdata;
			`QPCS_OFF_RCRDATA: rd_img = rcfg_rdata;
			`QPCS_OFF_FREQEN:  rd_img[0] = s_ff.freq_en;
			`QPCS_OFF_FREQRX:  rd_img[23:0] = rx_count;
			`QPCS_OFF_FREQTX:  rd_img[23:0] = tx_count;
			`QPCS_OFF_PMODE:   rd_img[7:0] = s_ff.prbs_mode;
			`QPCS_OFF_PLOW:    rd_img = prbs_img[31:0];
			`QPCS_OFF_PHIGH:   rd_img = prbs_img[63:32];
			default:           rd_img = 32'h0000_0000;
		endcase
	end

	// Trigger hits and FIFO threshold check
	always_comb begin
		tx_trig_hit = trig_pick(s_ff.tx_src, ext_trig, int_trig);
		rx_trig_hit = trig_pick(s_ff.rx_src, ext_trig, int_trig);
		case (s_ff.fifo_thr)
			`QPCS_THR_NONE: thr_met = 1'b1;
			`QPCS_THR_HALF: thr_met = fifo_half;
			`QPCS_THR_3Q:   thr_met = fifo_3q;
			`QPCS_THR_FULL: thr_met = fifo_full;
			default:        thr_met = 1'b0;
		endcase
	end

	// Next state: trigger sequencing, register writes, read answer
	always_comb begin
		nxt_s = s_ff;
		// Trigger latches clear when disarmed
		nxt_s.tx_trigd  = s_ff.tx_arm & (s_ff.tx_trigd | tx_trig_hit);
		nxt_s.rx_trigd  = s_ff.rx_arm & (s_ff.rx_trigd | rx_trig_hit);
		nxt_s.tx_run    = s_ff.tx_arm & s_ff.tx_trigd & thr_met;
		nxt_s.rx_accept = s_ff.rx_nowait | (s_ff.rx_arm & s_ff.rx_trigd);
		if (reg_wr) begin
			case (reg_addr)
				`QPCS_OFF_MODCFG: begin
					nxt_s.mod_lowpwr = reg_wdata[`QPCS_CFG_LOWPWR];
					nxt_s.xcvr_en    = reg_wdata[`QPCS_CFG_XCVREN];
				end
				`QPCS_OFF_PORTEN: nxt_s.port_en = reg_wdata[2:0];
				`QPCS_OFF_SYNC: begin
					nxt_s.tx_arm    = reg_wdata[`QPCS_SYNC_TXARM];
					nxt_s.fifo_thr  = reg_wdata[`QPCS_SYNC_THR];
					nxt_s.tx_src    = reg_wdata[`QPCS_SYNC_TXSRC];
					nxt_s.rx_arm    = reg_wdata[`QPCS_SYNC_RXARM];
					nxt_s.rx_nowait = reg_wdata[`QPCS_SYNC_NOWAIT];
					nxt_s.rx_src    = reg_wdata[`QPCS_SYNC_RXSRC];
				end
				`QPCS_OFF_RCADDR: begin
					nxt_s.rcfg_all_rst = reg_wdata[`QPCS_RC_ALLRST];
					nxt_s.xcvr_rst     = reg_wdata[`QPCS_RC_XRST];
					nxt_s.rcfg_addr    = reg_wdata[`QPCS_RC_ADDR];
				end
				`QPCS_OFF_RCWDATA: nxt_s.rcfg_wdata = reg_wdata;
				`QPCS_OFF_FREQEN:  nxt_s.freq_en = reg_wdata[0];
				`QPCS_OFF_PMODE:   nxt_s.prbs_mode = reg_wdata[7:0];
				`QPCS_OFF_PLOW: begin
					nxt_s.prbs_gen[3:0] = wr_gen[3:0];
					nxt_s.prbs_chk[3:0] = wr_chk[3:0];
				end
				`QPCS_OFF_PHIGH: begin
					nxt_s.prbs_gen[7:4] = wr_gen[7:4];
					nxt_s.prbs_chk[7:4] = wr_chk[7:4];
				end
				default: nxt_s.port_en = s_ff.port_en;
			endcase
		end
		// Read answer one cycle after the strobe, data held until next read
		nxt_s.rvalid = reg_rd;
		if (reg_rd) begin
			nxt_s.rdata = rd_img;
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from state flops
	assign reg_rdata     = s_ff.rdata;
	assign reg_rvalid    = s_ff.rvalid;
	assign mod_lowpwr    = s_ff.mod_lowpwr;
	assign xcvr_en       = s_ff.xcvr_en;
	assign second_pll_en = s_ff.port_en[2];
	assign first_pll_en  = s_ff.port_en[1];
	assign line_if_en    = s_ff.port_en[0];
	assign tx_run        = s_ff.tx_run;
	assign rx_accept     = s_ff.rx_accept;
	assign rcfg_all_rst  = s_ff.rcfg_all_rst;
	assign xcvr_rst      = s_ff.xcvr_rst;
	assign rcfg_addr     = s_ff.rcfg_addr;
	assign rcfg_wdata    = s_ff.rcfg_wdata;
	assign prbs_mode     = s_ff.prbs_mode;
	assign prbs_gen_en   = s_ff.prbs_gen;
	assign prbs_chk_en   = s_ff.prbs_chk;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Checks on reads and writes of the bank
	a_cfg_status_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_MODCFG |=> reg_rvalid && reg_rdata[6] == $past(mod_int)
			&& reg_rdata[5] == $past(mod_present))
		else $error("module config status bits wrong");
	a_cfg_ctrl_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_MODCFG |=> mod_lowpwr == $past(reg_wdata[2])
			&& xcvr_en == $past(reg_wdata[1]))
		else $error("module config control not taken");
	a_port_en_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_PORTEN |=> {second_pll_en, first_pll_en, line_if_en}
			== $past(reg_wdata[2:0]))
		else $error("port enable bits not taken");
	a_port_status_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_PSTAT |=> reg_rdata == {25'h000_0000, $past(rcfg_in_progress), 1'b0,
			$past(tx_pll_locked), $past(clkrec_lock_data), $past(clkrec_lock_ref), $past(rx_ready),
			$past(tx_ready)})
		else $error("port status image wrong");
	a_port_information_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_PINFO |=> reg_rdata == 32'h0000_0014)
		else $error("port information wrong");
	a_tx_run_cause: assert property (
		!s_ff.tx_arm |=> ##1 !tx_run)
		else $error("transmit ran while disarmed");
	a_tx_full_hold: assert property (
		s_ff.fifo_thr == 2'h3 && !fifo_full |=> !tx_run)
		else $error("transmit started below full threshold");
	a_rx_nowait: assert property (
		s_ff.rx_nowait |=> rx_accept)
		else $error("receive still waits for trigger");
	a_lane_lock_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_LOCK |=> reg_rdata[7:6] == {$past(lane_lock_data[3]),
			$past(lane_lock_ref[3])} && reg_rdata[31:8] == 24'h00_0000)
		else $error("lane lock image wrong");
	a_rcfg_ctrl_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_RCADDR |=> rcfg_all_rst == $past(reg_wdata[18])
			&& xcvr_rst == $past(reg_wdata[16]) && rcfg_addr == $past(reg_wdata[15:0]))
		else $error("reconfig control not taken");
	a_rcfg_busy_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_RCADDR |=> reg_rdata[17] == $past(rcfg_busy))
		else $error("reconfig busy bit wrong");
	a_prbs_low_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_PLOW |=> prbs_gen_en[3:0] == {$past(reg_wdata[24]),
			$past(reg_wdata[16]), $past(reg_wdata[8]), $past(reg_wdata[0])}
			&& prbs_chk_en[3] == $past(reg_wdata[25]))
		else $error("pattern test enables misplaced");
	a_reserved_zero: assert property (
		reg_rd && reg_addr == `QPCS_OFF_FRMCNT |=> reg_rdata == 32'h0000_0000)
		else $error("reserved register not zero");

	// Checks on data words and ignored writes
	a_reserved_write_kept: assert property (
		reg_wr && (reg_addr == `QPCS_OFF_PINFO || reg_addr == `QPCS_OFF_FRMCNT) |=>
			$stable({mod_lowpwr, xcvr_en, second_pll_en, first_pll_en, line_if_en, rcfg_all_rst, xcvr_rst,
			rcfg_addr, rcfg_wdata, prbs_mode, prbs_gen_en, prbs_chk_en}))
		else $error("ignored write changed a control output");
	a_rcfg_wdata_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_RCWDATA |=> rcfg_wdata == $past(reg_wdata))
		else $error("reconfig write data not taken");
	a_rcfg_rdata_read: assert property (
		reg_rd && reg_addr == `QPCS_OFF_RCRDATA |=> reg_rdata == $past(rcfg_rdata))
		else $error("reconfig read data wrong");
	a_freq_upper_zero: assert property (
		reg_rd && (reg_addr == `QPCS_OFF_FREQRX || reg_addr == `QPCS_OFF_FREQTX) |=> reg_rdata[31:24] == 8'h00)
		else $error("frequency reading upper bits not zero");
	a_prbs_high_write: assert property (
		reg_wr && reg_addr == `QPCS_OFF_PHIGH |=> prbs_gen_en[7:4] == {$past(reg_wdata[24]),
			$past(reg_wdata[16]), $past(reg_wdata[8]), $past(reg_wdata[0])}
			&& prbs_chk_en[6] == $past(reg_wdata[17]))
		else $error("upper lane pattern enables misplaced");

	c_tx_started: cover property (s_ff.tx_arm && s_ff.fifo_thr == 2'h2 ##1 tx_run);
	c_rx_triggered: cover property (s_ff.rx_arm && !s_ff.rx_nowait ##1 rx_accept);
	c_rcfg_read: cover property (reg_rd && reg_addr == `QPCS_OFF_RCRDATA);

endmodule : qpcs_port_regs

// ---- qpcs_far_model.sv ----
// Far-side model: optical module, transceiver lanes and reconfiguration block
`timescale 1ns/1ps

module qpcs_far_model (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [31:0] knob,
	input  wire logic [31:0] rd_word,
	input  wire logic        xcvr_en,
	input  wire logic        xcvr_rst,
	input  wire logic        rcfg_all_rst,
	input  wire logic  [7:0] prbs_chk_en,
	output logic             mod_int,
	output logic             mod_present,
	output logic             rcfg_in_progress,
	output logic             tx_pll_locked,
	output logic             clkrec_lock_data,
	output logic             clkrec_lock_ref,
	output logic             rx_ready,
	output logic             tx_ready,
	output logic       [3:0] lane_lock_data,
	output logic       [3:0] lane_lock_ref,
	output logic             rcfg_busy,
	output logic      [31:0] rcfg_rdata,
	output logic             rx_freq_tick,
	output logic             tx_freq_tick,
	output logic       [7:0] prbs_sync,
	output logic       [7:0] prbs_lerr,
	output logic       [7:0] prbs_rerr
);
	logic tick_ff;

	// Receive clock ticks every second cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= ~tick_ff;
		end
	end
	assign rx_freq_tick = tick_ff;
	assign tx_freq_tick = 1'b1;

	// Module and lane levels set by the bench; transmit PLL lock gated by xcvr_en, pattern sync following prbs_chk_en
	assign mod_int          = knob[0];
	assign mod_present      = knob[1];
	assign tx_pll_locked    = knob[2] & xcvr_en;
	assign clkrec_lock_data = knob[3];
	assign clkrec_lock_ref  = knob[4];
	assign lane_lock_data   = knob[11:8];
	assign lane_lock_ref    = knob[15:12];
	assign prbs_lerr        = knob[23:16];
	assign prbs_rerr        = knob[31:24];
	assign prbs_sync        = prbs_chk_en;
	assign rcfg_rdata       = rd_word;

	// Ready only while enabled and out of reset
	assign tx_ready         = xcvr_en & ~xcvr_rst;
	assign rx_ready         = xcvr_en & ~xcvr_rst & knob[3];

	// Busy for as long as the shared interface is held in reset
	assign rcfg_busy        = rcfg_all_rst;
	assign rcfg_in_progress = rcfg_all_rst;
endmodule : qpcs_far_model

// ---- qpcs_port_regs_tb.sv ----
// Self-checking bench for the optical port register bank
`timescale 1ns/1ps
`include "qpcs_consts.svh"

module qpcs_port_regs_tb;
	localparam int GATE = 16;
	logic        clk, resetn, reg_wr, reg_rd, ext_trig, int_trig, fifo_half, fifo_3q, fifo_full;
	logic [23:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, knob, rd_word, rcfg_rdata, rcfg_wdata;
	logic        reg_rvalid, mod_int, mod_present, mod_lowpwr, xcvr_en, second_pll_en, first_pll_en, line_if_en;
	logic        rcfg_in_progress, tx_pll_locked, clkrec_lock_data, clkrec_lock_ref, rx_ready, tx_ready;
	logic        tx_run, rx_accept, rcfg_busy, rcfg_all_rst, xcvr_rst, rx_freq_tick, tx_freq_tick;
	logic [3:0]  lane_lock_data, lane_lock_ref;
	logic [15:0] rcfg_addr;
	logic [7:0]  prbs_mode, prbs_gen_en, prbs_chk_en, prbs_sync, prbs_lerr, prbs_rerr;
	int          failures = 0;
	int          checked = 0;
	int          cycles = 0;

	// Design and far-side model
	qpcs_port_regs #(.FREQ_GATE_CYCLES(GATE)) dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .mod_int, .mod_present, .mod_lowpwr, .xcvr_en, .second_pll_en, .first_pll_en,
		.line_if_en, .rcfg_in_progress, .tx_pll_locked, .clkrec_lock_data, .clkrec_lock_ref, .rx_ready, .tx_ready,
		.lane_lock_data, .lane_lock_ref, .ext_trig, .int_trig, .fifo_half, .fifo_3q, .fifo_full, .tx_run,
		.rx_accept, .rcfg_busy, .rcfg_rdata, .rcfg_all_rst, .xcvr_rst, .rcfg_addr, .rcfg_wdata, .rx_freq_tick,
		.tx_freq_tick, .prbs_mode, .prbs_gen_en, .prbs_chk_en, .prbs_sync, .prbs_lerr, .prbs_rerr);
	qpcs_far_model far_side (.clk, .resetn, .knob, .rd_word, .xcvr_en, .xcvr_rst, .rcfg_all_rst, .prbs_chk_en,
		.mod_int, .mod_present, .rcfg_in_progress, .tx_pll_locked, .clkrec_lock_data, .clkrec_lock_ref,
		.rx_ready, .tx_ready, .lane_lock_data, .lane_lock_ref, .rcfg_busy, .rcfg_rdata, .rx_freq_tick,
		.tx_freq_tick, .prbs_sync, .prbs_lerr, .prbs_rerr);

	task automatic report_and_stop();
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [23:0] a, input logic [31:0] exp);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check("read valid", 32'h0000_0001, {31'h0, reg_rvalid});
		check($sformatf("read %h", a), exp, reg_rdata);
	endtask : rd

	// One trigger pulse, then time for latch and run flag to follow
	task automatic pulse(input logic internal);
		@(posedge clk);
		#1 int_trig = internal;
		ext_trig = ~internal;
		@(posedge clk);
		#1 int_trig = 1'b0;
		ext_trig = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse

	function automatic logic [31:0] prbs_word(input logic [3:0] gen, chk, sy, le, re);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int g = 0; g < 4; g++) begin
			w[g*8 +: 8] = {1'b0, re[g], le[g], sy[g], 2'b00, chk[g], gen[g]};
		end
		return w;
	endfunction : prbs_word

	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			report_and_stop();
		end
	end

	// Main sequence
	initial begin
		{resetn, reg_wr, reg_rd, ext_trig, int_trig, fifo_half, fifo_3q, fifo_full} = 8'h00;
		reg_addr = 24'h00_0000;
		reg_wdata = 32'h0000_0000;
		knob = 32'h0000_0003;
		rd_word = 32'h1234_5678;
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		rd(`QPCS_OFF_PINFO, {24'h0, 4'h1, `QPCS_PORT_NUM});
		wr(`QPCS_OFF_MODCFG, 32'hffff_ffff);
		check("mod_lowpwr", 32'h0000_0001, {31'h0, mod_lowpwr});
		check("xcvr_en", 32'h0000_0001, {31'h0, xcvr_en});
		rd(`QPCS_OFF_MODCFG, 32'h0000_0066);
		knob = 32'h0000_001c;
		wr(`QPCS_OFF_MODCFG, 32'h0000_0002);
		rd(`QPCS_OFF_MODCFG, 32'h0000_0002);
		wr(`QPCS_OFF_PORTEN, 32'hffff_ffff);
		rd(`QPCS_OFF_PORTEN, 32'h0000_0007);
		wr(`QPCS_OFF_PORTEN, 32'h0000_0005);
		check("pll enables", 32'h0000_0005, {29'h0, second_pll_en, first_pll_en, line_if_en});
		rd(`QPCS_OFF_PSTAT, 32'h0000_001f);
		knob = 32'h0000_6a08;
		rd(`QPCS_OFF_PSTAT, 32'h0000_000b);
		wr(`QPCS_OFF_LOCK, 32'hffff_ffff);
		rd(`QPCS_OFF_LOCK, 32'h0000_009c);
		// Reconfiguration window
		wr(`QPCS_OFF_RCADDR, 32'hffff_ffff);
		check("rcfg outputs", 32'h0003_ffff, {14'h0, rcfg_all_rst, xcvr_rst, rcfg_addr});
		rd(`QPCS_OFF_RCADDR, 32'h0007_ffff);
		rd(`QPCS_OFF_PSTAT, 32'h0000_0048);
		wr(`QPCS_OFF_RCADDR, 32'h0001_2345);
		rd(`QPCS_OFF_RCADDR, 32'h0001_2345);
		wr(`QPCS_OFF_RCWDATA, 32'ha5a5_5a5a);
		check("rcfg_wdata", 32'ha5a5_5a5a, rcfg_wdata);
		rd(`QPCS_OFF_RCWDATA, 32'ha5a5_5a5a);
		wr(`QPCS_OFF_RCRDATA, 32'h0000_0000);
		rd(`QPCS_OFF_RCRDATA, 32'h1234_5678);
		// Frequency measurement
		repeat (2 * GATE) @(posedge clk);
		rd(`QPCS_OFF_FREQRX, 32'h0000_0000);
		wr(`QPCS_OFF_FREQEN, 32'hffff_ffff);
		rd(`QPCS_OFF_FREQEN, 32'h0000_0001);
		repeat (3 * GATE) @(posedge clk);
		rd(`QPCS_OFF_FREQRX, GATE / 2);
		rd(`QPCS_OFF_FREQTX, GATE);
		wr(`QPCS_OFF_FREQEN, 32'h0000_0000);
		repeat (3 * GATE) @(posedge clk);
		rd(`QPCS_OFF_FREQTX, GATE);
		// Pattern test words
		knob = 32'hc35a_0000;
		wr(`QPCS_OFF_PLOW, 32'hffff_ffff);
		rd(`QPCS_OFF_PLOW, prbs_word(4'hf, 4'hf, 4'hf, 4'ha, 4'h3));
		wr(`QPCS_OFF_PLOW, 32'h0100_0002);
		check("gen/chk low", 32'h0000_0801, {16'h0, prbs_gen_en, prbs_chk_en});
		rd(`QPCS_OFF_PLOW, prbs_word(4'h8, 4'h1, 4'h1, 4'ha, 4'h3));
		wr(`QPCS_OFF_PHIGH, 32'h0002_0001);
		check("gen/chk high", 32'h0000_1841, {16'h0, prbs_gen_en, prbs_chk_en});
		rd(`QPCS_OFF_PHIGH, prbs_word(4'h1, 4'h4, 4'h4, 4'h5, 4'hc));
		wr(`QPCS_OFF_PMODE, 32'hffff_ffff);
		check("prbs_mode", 32'h0000_00ff, {24'h0, prbs_mode});
		rd(`QPCS_OFF_PMODE, 32'h0000_00ff);
		// Trigger arming, sources and FIFO thresholds
		wr(`QPCS_OFF_SYNC, 32'hffff_ffff);
		rd(`QPCS_OFF_SYNC, 32'h0000_b387);
		wr(`QPCS_OFF_SYNC, 32'h0000_8200);
		pulse(1'b1);
		pulse(1'b0);
		check("tx_run src 2", 32'h0000_0000, {31'h0, tx_run});
		wr(`QPCS_OFF_SYNC, 32'h0000_8100);
		pulse(1'b0);
		check("tx_run ext", 32'h0000_0000, {31'h0, tx_run});
		pulse(1'b1);
		check("tx_run int", 32'h0000_0001, {31'h0, tx_run});
		for (int t = 1; t < 4; t++) begin
			wr(`QPCS_OFF_SYNC, 32'h0000_0000);
			wr(`QPCS_OFF_SYNC, 32'h0000_8100 | (32'(t) << 12));
			pulse(1'b1);
			check("tx_run held", 32'h0000_0000, {31'h0, tx_run});
			{fifo_full, fifo_3q, fifo_half} = 3'b001 << (t - 1);
			repeat (2) @(posedge clk);
			#1 check("tx_run fill", 32'h0000_0001, {31'h0, tx_run});
			{fifo_full, fifo_3q, fifo_half} = 3'b000;
		end
		wr(`QPCS_OFF_SYNC, 32'h0000_0080);
		pulse(1'b1);
		check("rx_accept int", 32'h0000_0000, {31'h0, rx_accept});
		pulse(1'b0);
		check("rx_accept ext", 32'h0000_0001, {31'h0, rx_accept});
		wr(`QPCS_OFF_SYNC, 32'h0000_0004);
		repeat (2) @(posedge clk);
		#1 check("rx_accept nowait", 32'h0000_0001, {31'h0, rx_accept});
		wr(`QPCS_OFF_SYNC, 32'h0000_0000);
		repeat (2) @(posedge clk);
		#1 check("rx_accept off", 32'h0000_0000, {31'h0, rx_accept});
		// Reserved and read-only places
		wr(`QPCS_OFF_FRMCNT, 32'hffff_ffff);
		rd(`QPCS_OFF_FRMCNT, 32'h0000_0000);
		rd(`QPCS_OFF_MODST2, 32'h0000_0000);
		rd(24'h84_0090, 32'h0000_0000);
		wr(`QPCS_OFF_PINFO, 32'h0000_0000);
		rd(`QPCS_OFF_PINFO, {24'h0, 4'h1, `QPCS_PORT_NUM});
		report_and_stop();
	end
endmodule : qpcs_port_regs_tb
